/* common/sbr_regs.vh */
/*
  register indices, field positions and reset values of the break and
  reset status register bank.
  assumes: included by bare name from the core files.
*/
`ifndef SBR_REGS_VH
`define SBR_REGS_VH

// ----------------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define SBR_IDX_BREAK_WAKEUP_STATUS 16'hfe00
`define SBR_IDX_RESET_CAUSE_STATUS 16'hfe01
`define SBR_IDX_BREAK_FLAG_CONTROL 16'hfe03
`define SBR_IDX_IRQ_STATUS 16'hfe08
`define SBR_IDX_IRQ_MASK 16'hfe09

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SBR_BIT_BREAK_WAKEUP 1
`define SBR_BIT_POWER_ON 7
`define SBR_BIT_EXTERNAL 6
`define SBR_BIT_WATCHDOG 5
`define SBR_BIT_ILL_OPCODE 4
`define SBR_BIT_ILL_ADDRESS 3
`define SBR_BIT_MONITOR 2
`define SBR_BIT_LOW_VOLTAGE 1
`define SBR_BIT_CLEAR_ENABLE 7
`define SBR_BIT_IRQ_WAKEUP 0
`define SBR_BIT_IRQ_RESET 1

// ----------------------------------------------------------------------
// implemented bits and reset values
// ----------------------------------------------------------------------
`define SBR_MASK_BREAK_WAKEUP 8'h02
`define SBR_MASK_RESET_CAUSE 8'hfe
`define SBR_MASK_FLAG_CONTROL 8'h80
`define SBR_MASK_IRQ 8'h03
`define SBR_RST_BREAK_WAKEUP 8'h00
`define SBR_RST_RESET_CAUSE 8'h80
`define SBR_RST_FLAG_CONTROL 8'h00
`define SBR_RST_IRQ_STATUS 8'h00
`define SBR_RST_IRQ_MASK 8'h00

// ----------------------------------------------------------------------
// avalon response codes
// ----------------------------------------------------------------------
`define SBR_RESP_OKAY 2'b00
`define SBR_RESP_SLVERR 2'b10

`endif

/* core/sbr_sync.v */
/*
  two flip-flop level synchroniser, one lane per bit.
  assumes: inputs come from outside the CLK domain; en freezes it.
*/
`timescale 1ns/1ps

module sbr_sync #(
  parameter W = 2,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire clk,
  input wire rstn,
  input wire en,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);

  genvar i;

  // ----------------------------------------------------------------------
  // per-bit stages
  // ----------------------------------------------------------------------
  generate
    for (i = 0; i < W; i = i + 1) begin : g_lane
      reg meta_reg;
      reg sync_reg;
      always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          meta_reg <= RST_VAL[i];
          sync_reg <= RST_VAL[i];
        end else if (en) begin
          meta_reg <= din[i];
          sync_reg <= meta_reg;
        end
      end
      assign dout[i] = sync_reg;
    end
  endgenerate

endmodule // sbr_sync

/* core/sbr_top.v */
/*
  break wakeup, reset cause and break flag control registers on an
  avalon-mm slave with waitrequest, plus a small interrupt unit.
  assumes: RSTN is the power-on reset; other reset causes arrive as
  one-cycle CLK pulses except the reset pin and low-voltage trip, which
  are asynchronous levels.
*/
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "sbr_regs.vh"

// How it works
// - three byte registers at indices fe00, fe01, fe03
// - break exit from stop/wait sets wakeup flag
// - writing zero or any reset clears it
// - reading reset status clears it afterwards
// - power-on sets power flag, clears others
// - reset flags accumulate until read
// - reset pin assertion sets external flag
// - watchdog timeout sets watchdog flag
// - illegal opcode sets its flag
// - illegal address flag only on opcode fetch
// - monitor mode entry sets monitor flag
// - low-voltage trip sets low-voltage flag
// - clear enable gates flag clearing during break
// - clears outside break always allowed
module sbr_top #(
  parameter AW = 18
) (
  input wire CLK,
  input wire RSTN,
  input wire CE,
  input wire [AW-1:0] ADDRESS,
  input wire READ,
  input wire WRITE,
  input wire [31:0] WRITEDATA,
  input wire [3:0] BYTEENABLE,
  output reg [31:0] READDATA,
  output reg WAITREQUEST,
  output reg [1:0] RESPONSE,
  input wire BREAK_ACTIVE,
  input wire LOWPOWER_ACTIVE,
  input wire BREAK_IRQ,
  input wire RST_PIN_N,
  input wire WDOG_TIMEOUT,
  input wire ILL_OPCODE,
  input wire ILL_ADDR,
  input wire OPCODE_FETCH,
  input wire MON_ENTRY,
  input wire LV_TRIP,
  output reg BREAK_CLEAR_OK,
  output reg IRQ
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  reg [7:0] wakeup_reg;
  reg [7:0] wakeup_next;
  reg [7:0] cause_reg;
  reg [7:0] cause_next;
  reg [7:0] ctrl_reg;
  reg [7:0] ctrl_next;
  reg [7:0] irq_stat_reg;
  reg [7:0] irq_stat_next;
  reg [7:0] irq_mask_reg;
  reg [7:0] irq_mask_next;
  reg pin_seen_reg;
  reg lv_seen_reg;
  reg [7:0] rd_byte;
  reg hit;
  reg [7:0] cause_set;
  reg [7:0] wakeup_set;
  reg [7:0] cause_clr;
  reg [7:0] wakeup_clr;
  reg [7:0] irq_set;
  reg [7:0] irq_clr;
  wire [1:0] sync_out;
  wire pin_low;
  wire lv_high;
  wire [15:0] word_idx;
  wire [33:0] addr_ext;
  wire aligned;
  wire req;
  wire accept;
  wire finish;
  wire wr_lo;
  wire clear_ok;
  wire sel_wakeup;
  wire sel_cause;
  wire sel_ctrl;
  wire sel_istat;
  wire sel_imask;
  wire pin_event;
  wire lv_event;
  wire any_reset;

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  sbr_sync #(
    .W(2),
    .RST_VAL(2'b01)
  ) u_sync (
    .clk(CLK),
    .rstn(RSTN),
    .en(CE),
    .din({LV_TRIP, RST_PIN_N}),
    .dout(sync_out)
  );

  assign pin_low = ~sync_out[0];
  assign lv_high = sync_out[1];

  // edge detect on the synchronised levels
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      pin_seen_reg <= 1'b0;
      lv_seen_reg <= 1'b0;
    end else if (CE) begin
      pin_seen_reg <= pin_low;
      lv_seen_reg <= lv_high;
    end
  end

  assign pin_event = pin_low & ~pin_seen_reg;
  assign lv_event = lv_high & ~lv_seen_reg;

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  // zero-extend the byte address, then take the word index
  assign addr_ext = {{(34-AW){1'b0}}, ADDRESS};
  assign word_idx = addr_ext[17:2];
  assign aligned = (ADDRESS[1:0] == 2'b00);
  assign req = (READ | WRITE) & CE;
  // accept on the first cycle of a request, finish on the ack cycle
  assign accept = req & WAITREQUEST;
  assign finish = req & ~WAITREQUEST;
  assign wr_lo = WRITE & BYTEENABLE[0];

  assign sel_wakeup = aligned & (word_idx == `SBR_IDX_BREAK_WAKEUP_STATUS);
  assign sel_cause = aligned & (word_idx == `SBR_IDX_RESET_CAUSE_STATUS);
  assign sel_ctrl = aligned & (word_idx == `SBR_IDX_BREAK_FLAG_CONTROL);
  assign sel_istat = aligned & (word_idx == `SBR_IDX_IRQ_STATUS);
  assign sel_imask = aligned & (word_idx == `SBR_IDX_IRQ_MASK);

  // ----------------------------------------------------------------------
  // break clear gating
  // ----------------------------------------------------------------------
  // clearing allowed outside break, or in break with enable set
  assign clear_ok = ~BREAK_ACTIVE |
    ctrl_reg[`SBR_BIT_CLEAR_ENABLE];

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  always @* begin
    hit = sel_wakeup | sel_cause | sel_ctrl | sel_istat | sel_imask;
    rd_byte = 8'h00;
    if (sel_wakeup) begin
      rd_byte = wakeup_reg & `SBR_MASK_BREAK_WAKEUP;
    end else if (sel_cause) begin
      rd_byte = cause_reg & `SBR_MASK_RESET_CAUSE;
    end else if (sel_ctrl) begin
      rd_byte = ctrl_reg & `SBR_MASK_FLAG_CONTROL;
    end else if (sel_istat) begin
      rd_byte = irq_stat_reg & `SBR_MASK_IRQ;
    end else if (sel_imask) begin
      rd_byte = irq_mask_reg & `SBR_MASK_IRQ;
    end
  end

  // ----------------------------------------------------------------------
  // event collection
  // ----------------------------------------------------------------------
  always @* begin
    cause_set = 8'h00;
    cause_set[`SBR_BIT_EXTERNAL] = pin_event;
    cause_set[`SBR_BIT_WATCHDOG] = WDOG_TIMEOUT;
    cause_set[`SBR_BIT_ILL_OPCODE] = ILL_OPCODE;
    cause_set[`SBR_BIT_ILL_ADDRESS] = ILL_ADDR & OPCODE_FETCH;
    cause_set[`SBR_BIT_MONITOR] = MON_ENTRY;
    cause_set[`SBR_BIT_LOW_VOLTAGE] = lv_event;
    wakeup_set = 8'h00;
    wakeup_set[`SBR_BIT_BREAK_WAKEUP] = BREAK_IRQ &
      LOWPOWER_ACTIVE;
  end

  assign any_reset = |cause_set;

  // ----------------------------------------------------------------------
  // reset cause next value
  // ----------------------------------------------------------------------
  always @* begin
    cause_clr = 8'h00;
    // clear after the read data has gone out
    if (finish & READ & sel_cause & clear_ok) begin
      cause_clr = 8'hff;
    end
    // set wins over the read clear
    cause_next = (cause_reg & ~cause_clr) | cause_set;
  end

  // ----------------------------------------------------------------------
  // break wakeup next value
  // ----------------------------------------------------------------------
  always @* begin
    wakeup_clr = 8'h00;
    if (finish & wr_lo & sel_wakeup & clear_ok &
        ~WRITEDATA[`SBR_BIT_BREAK_WAKEUP]) begin
      wakeup_clr[`SBR_BIT_BREAK_WAKEUP] = 1'b1;
    end
    if (any_reset) begin
      wakeup_clr[`SBR_BIT_BREAK_WAKEUP] = 1'b1;
    end
    if (any_reset) begin
      wakeup_next = wakeup_reg & ~wakeup_clr;
    end else begin
      wakeup_next = (wakeup_reg & ~wakeup_clr) | wakeup_set;
    end
  end

  // ----------------------------------------------------------------------
  // control and mask next values
  // ----------------------------------------------------------------------
  always @* begin
    ctrl_next = ctrl_reg;
    irq_mask_next = irq_mask_reg;
    if (finish & wr_lo & sel_ctrl) begin
      ctrl_next = WRITEDATA[7:0] & `SBR_MASK_FLAG_CONTROL;
    end
    if (finish & wr_lo & sel_imask) begin
      irq_mask_next = WRITEDATA[7:0] & `SBR_MASK_IRQ;
    end
  end

  // ----------------------------------------------------------------------
  // interrupt status next value
  // ----------------------------------------------------------------------
  always @* begin
    irq_clr = 8'h00;
    irq_set = 8'h00;
    if (finish & wr_lo & sel_istat) begin
      irq_clr = WRITEDATA[7:0] & `SBR_MASK_IRQ;
    end
    // set wins over the write-one clear
    irq_set[`SBR_BIT_IRQ_WAKEUP] = |wakeup_set & ~any_reset;
    irq_set[`SBR_BIT_IRQ_RESET] = any_reset;
    irq_stat_next = (irq_stat_reg & ~irq_clr) | irq_set;
  end

  // ----------------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------------
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      wakeup_reg <= `SBR_RST_BREAK_WAKEUP;
    end else if (CE) begin
      wakeup_reg <= wakeup_next & `SBR_MASK_BREAK_WAKEUP;
    end
  end

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      cause_reg <= `SBR_RST_RESET_CAUSE;
    end else if (CE) begin
      cause_reg <= cause_next & `SBR_MASK_RESET_CAUSE;
    end
  end

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      ctrl_reg <= `SBR_RST_FLAG_CONTROL;
    end else if (CE) begin
      ctrl_reg <= ctrl_next;
    end
  end

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_stat_reg <= `SBR_RST_IRQ_STATUS;
    end else if (CE) begin
      irq_stat_reg <= irq_stat_next & `SBR_MASK_IRQ;
    end
  end

  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      irq_mask_reg <= `SBR_RST_IRQ_MASK;
    end else if (CE) begin
      irq_mask_reg <= irq_mask_next;
    end
  end

  // ----------------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------------
  // one wait cycle, then a single ack cycle with data and response
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      WAITREQUEST <= 1'b1;
      READDATA <= 32'h00000000;
      RESPONSE <= `SBR_RESP_OKAY;
    end else if (CE) begin
      if (accept) begin
        WAITREQUEST <= 1'b0;
        RESPONSE <= hit ? `SBR_RESP_OKAY : `SBR_RESP_SLVERR;
        if (READ) begin
          READDATA <= {24'h000000, rd_byte};
        end else begin
          READDATA <= 32'h00000000;
        end
      end else begin
        WAITREQUEST <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // side outputs
  // ----------------------------------------------------------------------
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      BREAK_CLEAR_OK <= 1'b1;
    end else if (CE) begin
      BREAK_CLEAR_OK <= ~BREAK_ACTIVE |
        ctrl_next[`SBR_BIT_CLEAR_ENABLE];
    end
  end

  // ----------------------------------------------------------------------
  // interrupt output
  // ----------------------------------------------------------------------
  always @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      IRQ <= 1'b0;
    end else if (CE) begin
      IRQ <= |(irq_stat_next & irq_mask_next & `SBR_MASK_IRQ);
    end
  end

endmodule // sbr_top

/* sim/sbr_top_sva.sv */
/*
  assertion checker for the sbr_top bus slave and break clear output.
  assumes: bound onto sbr_top; one clock, RSTN async active low.
*/
`timescale 1ns/1ps

module sbr_top_chk #(
  parameter AW = 18
) (
  input logic CLK,
  input logic RSTN,
  input logic CE,
  input logic [AW-1:0] ADDRESS,
  input logic READ,
  input logic WRITE,
  input logic [31:0] READDATA,
  input logic WAITREQUEST,
  input logic [1:0] RESPONSE,
  input logic BREAK_ACTIVE,
  input logic BREAK_CLEAR_OK
);
  // ----------------------------------------------------------------
  // decode and sequences
  // ----------------------------------------------------------------
  wire [17:0] a = ADDRESS[17:0];
  wire mapped = a == 18'h3f800 || a == 18'h3f804 || a == 18'h3f80c ||
    a == 18'h3f820 || a == 18'h3f824;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence s_req;
    CE && (READ || WRITE) && WAITREQUEST;
  endsequence
  sequence s_rd_at(x);
    CE && READ && WAITREQUEST && a == x;
  endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_req_ack;
    s_req |=> !WAITREQUEST;
  endproperty
  property p_ack_pulse;
    CE && !WAITREQUEST |=> WAITREQUEST;
  endproperty
  property p_err_resp;
    s_req ##0 !mapped |=> RESPONSE == 2'b10;
  endproperty
  property p_ok_resp;
    s_req ##0 mapped |=> RESPONSE == 2'b00;
  endproperty
  property p_bad_rd_zero;
    s_req ##0 (READ && !mapped) |=> READDATA == 32'h0;
  endproperty
  property p_bws_zero;
    s_rd_at(18'h3f800) |=> (READDATA & 32'hfffffffd) == 32'h0;
  endproperty
  property p_rcs_zero;
    s_rd_at(18'h3f804) |=> (READDATA & 32'hffffff01) == 32'h0;
  endproperty
  property p_bfc_zero;
    s_rd_at(18'h3f80c) |=> (READDATA & 32'hffffff7f) == 32'h0;
  endproperty
  property p_bco;
    CE && !BREAK_ACTIVE |=> BREAK_CLEAR_OK;
  endproperty
  a_req_ack: assert property (p_req_ack)
    else $error("no ack one cycle after request");
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack longer than one cycle");
  a_err_resp: assert property (p_err_resp)
    else $error("unmapped access without error response");
  a_ok_resp: assert property (p_ok_resp)
    else $error("mapped access with error response");
  a_bad_rd_zero: assert property (p_bad_rd_zero)
    else $error("unmapped read data not zero");
  a_bws_zero: assert property (p_bws_zero)
    else $error("unused wakeup status bits not zero");
  a_rcs_zero: assert property (p_rcs_zero)
    else $error("unused reset cause bits not zero");
  a_bfc_zero: assert property (p_bfc_zero)
    else $error("unused flag control bits not zero");
  a_bco: assert property (p_bco)
    else $error("clear not allowed outside break");
endmodule // sbr_top_chk

bind sbr_top sbr_top_chk #(.AW(AW)) u_chk (
  .CLK(CLK), .RSTN(RSTN), .CE(CE), .ADDRESS(ADDRESS), .READ(READ),
  .WRITE(WRITE), .READDATA(READDATA), .WAITREQUEST(WAITREQUEST),
  .RESPONSE(RESPONSE), .BREAK_ACTIVE(BREAK_ACTIVE),
  .BREAK_CLEAR_OK(BREAK_CLEAR_OK)
);

/* sim/tb_sbr_top.sv */
/*
  self-checking bench for sbr_top: table of bus accesses, then events.
  assumes: checker bound from sbr_top_sva.sv; CE and BYTEENABLE tied.
*/
`timescale 1ns/1ps

module tb_sbr_top;
  typedef struct packed {
    logic w;
    logic [17:0] a;
    logic [7:0] d;
    logic [7:0] rd;
    logic [1:0] rs;
  } sbr_row_t;
  localparam [17:0] A_BWS = 18'h3f800;
  localparam [17:0] A_RCS = 18'h3f804;
  localparam [17:0] A_BFC = 18'h3f80c;
  localparam [17:0] A_IST = 18'h3f820;
  localparam [17:0] A_IMK = 18'h3f824;
  logic clk = 1'b0, rstn = 1'b0, read = 1'b0, write = 1'b0, brk = 1'b0;
  logic lp = 1'b0, birq = 1'b0, pin_n = 1'b1, wdog = 1'b0, illegal_opcode_reset_flag = 1'b0;
  logic illegal_address_reset_flag = 1'b0, fetch = 1'b0, mon = 1'b0, lv = 1'b0;
  logic [17:0] address = 18'h0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] rdv;
  logic [1:0] rsv;
  wire [31:0] readdata;
  wire [1:0] resp;
  wire waitreq, bco, irq;
  int fail_count = 0;
  int cmp_count = 0;
  sbr_row_t rows [14] = '{
    '{1'b0, A_RCS, 8'h00, 8'h80, 2'b00}, '{1'b0, A_RCS, 8'h00, 8'h00, 2'b00},
    '{1'b1, A_RCS, 8'hff, 8'h00, 2'b00}, '{1'b0, A_RCS, 8'h00, 8'h00, 2'b00},
    '{1'b0, A_BWS, 8'h00, 8'h00, 2'b00}, '{1'b0, A_BFC, 8'h00, 8'h00, 2'b00},
    '{1'b1, A_BFC, 8'hff, 8'h00, 2'b00}, '{1'b0, A_BFC, 8'h00, 8'h80, 2'b00},
    '{1'b1, A_BFC, 8'h00, 8'h00, 2'b00}, '{1'b1, A_BWS, 8'hff, 8'h00, 2'b00},
    '{1'b0, A_BWS, 8'h00, 8'h00, 2'b00}, '{1'b1, 18'h3f808, 8'hff, 8'h00, 2'b10},
    '{1'b0, 18'h3f808, 8'h00, 8'h00, 2'b10},
    '{1'b0, 18'h3f801, 8'h00, 8'h00, 2'b10}};

  always #2 clk = ~clk;

  sbr_top DUT (.CLK(clk), .RSTN(rstn), .CE(1'b1), .ADDRESS(address),
    .READ(read), .WRITE(write), .WRITEDATA(writedata), .BYTEENABLE(4'h1),
    .READDATA(readdata), .WAITREQUEST(waitreq), .RESPONSE(resp),
    .BREAK_ACTIVE(brk), .LOWPOWER_ACTIVE(lp), .BREAK_IRQ(birq),
    .RST_PIN_N(pin_n), .WDOG_TIMEOUT(wdog), .ILL_OPCODE(illegal_opcode_reset_flag),
    .ILL_ADDR(illegal_address_reset_flag), .OPCODE_FETCH(fetch), .MON_ENTRY(mon), .LV_TRIP(lv),
    .BREAK_CLEAR_OK(bco), .IRQ(irq));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task results;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task acc(input logic w, input logic [17:0] a, input logic [7:0] d);
    int n;
    read <= !w;
    write <= w;
    address <= a;
    writedata <= {24'h0, d};
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    if (waitreq !== 1'b0) begin
      fail_count++;
      results();
    end
    rdv = readdata;
    rsv = resp;
    read <= 1'b0;
    write <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input string nm, input logic [17:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00);
    chk(nm, rdv, {24'h0, e});
  endtask
  task ev(input logic [6:0] v);
    {birq, lp, wdog, illegal_opcode_reset_flag, illegal_address_reset_flag, fetch, mon} <= v;
    @(posedge clk);
    {birq, lp, wdog, illegal_opcode_reset_flag, illegal_address_reset_flag, fetch, mon} <= 7'h00;
    @(posedge clk);
  endtask

  // ----------------------------------------------------------------
  // sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      acc(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk("row data", rdv, {24'h0, rows[i].rd});
      chk("row resp", {30'h0, rsv}, {30'h0, rows[i].rs});
    end
    $display("register table done");
    ev(7'h40);
    rd("wake no lowpower", A_BWS, 8'h00);
    ev(7'h60);
    rd("wake set", A_BWS, 8'h02);
    chk("irq masked", {31'h0, irq}, 32'h0);
    acc(1'b1, A_IMK, 8'h01);
    chk("irq on", {31'h0, irq}, 32'h1);
    brk <= 1'b1;
    acc(1'b1, A_BWS, 8'h00);
    chk("clear ok in break", {31'h0, bco}, 32'h0);
    rd("wake kept", A_BWS, 8'h02);
    brk <= 1'b0;
    acc(1'b1, A_BWS, 8'h00);
    rd("wake clear", A_BWS, 8'h00);
    chk("clear ok after break", {31'h0, bco}, 32'h1);
    acc(1'b1, A_IST, 8'h01);
    chk("irq off", {31'h0, irq}, 32'h0);
    brk <= 1'b1;
    acc(1'b1, A_BFC, 8'h80);
    chk("clear ok enabled", {31'h0, bco}, 32'h1);
    ev(7'h60);
    acc(1'b1, A_BWS, 8'h00);
    rd("wake clear enabled", A_BWS, 8'h00);
    acc(1'b1, A_BFC, 8'h00);
    brk <= 1'b0;
    $display("wakeup test done");
    ev(7'h60);
    ev(7'h10);
    ev(7'h08);
    rd("wdog and opcode", A_RCS, 8'h30);
    rd("wake by cause", A_BWS, 8'h00);
    ev(7'h04);
    rd("data address", A_RCS, 8'h00);
    ev(7'h06);
    ev(7'h01);
    rd("fetch and monitor", A_RCS, 8'h0c);
    pin_n <= 1'b0;
    repeat (3) @(posedge clk);
    pin_n <= 1'b1;
    lv <= 1'b1;
    repeat (3) @(posedge clk);
    lv <= 1'b0;
    repeat (4) @(posedge clk);
    rd("pin and voltage", A_RCS, 8'h42);
    fork
      acc(1'b0, A_RCS, 8'h00);
      begin
        @(posedge clk);
        wdog <= 1'b1;
        @(posedge clk);
        wdog <= 1'b0;
      end
    join
    rd("cause beats clear", A_RCS, 8'h20);
    brk <= 1'b1;
    ev(7'h10);
    rd("read in break", A_RCS, 8'h20);
    rd("kept in break", A_RCS, 8'h20);
    brk <= 1'b0;
    rd("read after break", A_RCS, 8'h20);
    rd("cleared after break", A_RCS, 8'h00);
    $display("reset cause test done");
    ev(7'h10);
    ev(7'h60);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    rd("power on", A_RCS, 8'h80);
    rd("power on wake", A_BWS, 8'h00);
    $display("power on test done");
    results();
  end
endmodule // tb_sbr_top
